// >>> shared/flow_out_pkg.sv
/*
  Shared constants for the flow pulse and frequency output stage: clock
  figures, setting limits, reset values, mode codes, register offsets and
  the loop current levels. Assumes a 20 MHz system clock.
*/
package flow_out_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam logic [4:0] REFRESH_MS = 5'h14;

  localparam logic [14:0] WIDTH_MS_MIN = 15'h0001;
  localparam logic [14:0] WIDTH_MS_MAX = 15'h4e20;
  localparam logic [14:0] WIDTH_MS_RST = 15'h000a;
  localparam logic [10:0] FREQ_MAX_MIN = 11'h032;
  localparam logic [10:0] FREQ_MAX_MAX = 11'h3e8;
  localparam logic [10:0] FREQ_MAX_RST = 11'h1f4;
  localparam logic [6:0] OVF_PCT_MIN = 7'h01;
  localparam logic [6:0] OVF_PCT_MAX = 7'h64;
  localparam logic [6:0] OVF_PCT_RST = 7'h01;
  localparam logic [23:0] PULSE_VOL_RST = 24'h0186a0;
  localparam logic [7:0] USER_FACTOR_RST = 8'h01;
  localparam logic [23:0] VAL_HI_RST = 24'h00ffff;
  localparam logic [15:0] RANGE_END_RST = 16'h0064;

  localparam logic [11:0] CTRL_MIN_MS = 12'h1f4;
  localparam logic [11:0] CTRL_MAX_MS = 12'hfa0;

  localparam logic [47:0] NCO_K = 48'h0000_0000_00d7;
  localparam logic [47:0] PCT_FULL = 48'h0000_0000_0064;
  localparam logic [63:0] RT_LIMIT = 64'h0000_0000_0000_57e4;
  localparam logic [63:0] UL_PER_L = 64'h0000_0000_000f_4240;

  localparam logic [14:0] UA_FAULT = 15'h0e10;
  localparam logic [14:0] UA_LOW = 15'h0ed8;
  localparam logic [14:0] UA_4MA = 15'h0fa0;
  localparam logic [14:0] UA_20MA = 15'h4e20;
  localparam logic [14:0] UA_HIGH = 15'h5014;
  localparam logic [14:0] UA_OVER = 15'h55f0;
  localparam logic [47:0] UA_SPAN = 48'h0000_0000_3e80;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h1;
  localparam logic [1:0] MODE_FREQ = 2'h2;
  localparam logic [1:0] MODE_CTRL = 2'h3;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PULSE_WIDTH = 8'h04;
  localparam logic [7:0] OFS_PULSE_VOL = 8'h08;
  localparam logic [7:0] OFS_USER_FACTOR = 8'h0c;
  localparam logic [7:0] OFS_FREQ_MAX = 8'h10;
  localparam logic [7:0] OFS_OVF_PCT = 8'h14;
  localparam logic [7:0] OFS_VAL_LO = 8'h18;
  localparam logic [7:0] OFS_VAL_HI = 8'h1c;
  localparam logic [7:0] OFS_RANGE_END = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_OWED1 = 8'h28;
  localparam logic [7:0] OFS_OWED2 = 8'h2c;
endpackage

// >>> src/pulse_freq_chan.sv
/*
  One configurable output channel: volume pulse train and square-wave
  frequency generator behind a push-pull pin driver. Assumes millisecond
  ticks and 20 ms refresh strobes from the parent on the same clock.
*/
`timescale 1ns/1ps
module pulse_freq_chan
  import flow_out_pkg::*;
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [1:0] mode_i,
  input wire logic tick_ms_i,
  input wire logic refresh_i,
  input wire logic [14:0] width_ms_i,
  input wire logic [31:0] pulse_vol_i,
  input wire logic [15:0] vol_inc_i,
  input wire logic vol_valid_i,
  input wire logic overflow_i,
  input wire logic measuring_i,
  input wire logic [31:0] nco_inc_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic [15:0] owed_o
);
  typedef enum logic [1:0] {P_IDLE, P_HIGH, P_LOW} pulse_state_e;
  pulse_state_e state_r;
  logic [31:0] period_acc_r;
  logic [31:0] bank_r;
  logic [14:0] left_r;
  logic [31:0] phase_r;
  logic pulse_on;
  logic conv;
  logic start;

  assign pulse_on = (mode_i == MODE_PULSE);
  // One pulse volume is converted per clock, which drains a full period long before the next.
  assign conv = pulse_on && !refresh_i && (pulse_vol_i != 32'h0) && (bank_r >= pulse_vol_i)
    && (owed_o != 16'hffff);
  assign start = pulse_on && (state_r == P_IDLE) && tick_ms_i && (owed_o != 16'h0)
    && measuring_i && !overflow_i;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      period_acc_r <= 32'h0;
    end else if (!pulse_on) begin
      period_acc_r <= 32'h0;
    end else if (refresh_i) begin
      period_acc_r <= vol_valid_i ? {16'h0, vol_inc_i} : 32'h0;
    end else if (vol_valid_i) begin
      period_acc_r <= period_acc_r + {16'h0, vol_inc_i};
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_r <= 32'h0;
    end else if (!pulse_on) begin
      bank_r <= 32'h0;
    end else if (refresh_i) begin
      bank_r <= bank_r + period_acc_r;
    end else if (conv) begin
      bank_r <= bank_r - pulse_vol_i;
    end
  end

  // Owed pulses survive menu mode and are paid out once measuring resumes.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      owed_o <= 16'h0;
    end else if (!pulse_on) begin
      owed_o <= 16'h0;
    end else begin
      owed_o <= owed_o + {15'h0, conv} - {15'h0, start};
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= P_IDLE;
      left_r <= 15'h0;
    end else begin
      case (state_r)
        P_IDLE: begin
          if (start) begin
            state_r <= P_HIGH;
            left_r <= width_ms_i;
          end
        end
        P_HIGH: begin
          if (tick_ms_i) begin
            if (left_r <= 15'h1) begin
              state_r <= P_LOW;
              left_r <= width_ms_i;
            end else begin
              left_r <= left_r - 15'h1;
            end
          end
        end
        P_LOW: begin
          if (tick_ms_i) begin
            if (left_r <= 15'h1) begin
              state_r <= P_IDLE;
            end else begin
              left_r <= left_r - 15'h1;
            end
          end
        end
        default: state_r <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r <= 32'h0;
    end else if (mode_i == MODE_FREQ) begin
      phase_r <= phase_r + nco_inc_i;
    end else begin
      phase_r <= 32'h0;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_oe_o <= pulse_on || (mode_i == MODE_FREQ);
      if (pulse_on) begin
        pin_o <= overflow_i || (state_r == P_HIGH);
      end else if (mode_i == MODE_FREQ) begin
        pin_o <= phase_r[31];
      end else begin
        pin_o <= 1'b0;
      end
    end
  end

  a_overflow_high: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (pulse_on && overflow_i) |=> pin_o)
    else $error("pulse pin not high during overflow");
  a_menu_no_start: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (state_r == P_IDLE && !measuring_i) |=> state_r != P_HIGH)
    else $error("pulse started outside measuring mode");
  a_owed_paid: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (start && !conv) |=> owed_o == $past(owed_o) - 16'h1)
    else $error("owed count not reduced on pulse start");
  a_push_pull_en: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (mode_i == MODE_PULSE) [*2] |-> pin_oe_o)
    else $error("pulse pin not driven both ways");
  c_pulse_train: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    start ##[1:1000] state_r == P_LOW ##[1:1000] start);
  c_menu_hold: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    (!measuring_i && owed_o != 16'h0) ##1 measuring_i);
endmodule

// >>> src/flow_pulse_frequency_output.sv
/*
  Output stage of a flowmeter: register file, millisecond and 20 ms
  timebase, two configurable output channels, frequency scaling, control
  input on output 1 and the loop current mapping with optional fault and
  range levels. Assumes volume increments and measured values arrive from
  logic on the same clock; the output 1 pin level comes from outside.
*/
// Contract
// - Pulse width fixed, 1 ms to 20 s.
// - Refresh every 20 ms, sum previous volume.
// - Pulse count from volume, emitted as train.
// - Pulse pin drives high and low.
// - Overflow stops pulses, pin held high.
// - Real-time only if range limit formula holds.
// - Pulses only in measuring mode.
// - Menu-mode pulses kept and paid later.
// - Pulse volume is volume per pulse.
// - User unit litres multiplies pulse volume.
// - Frequency proportional, equal high and low.
// - Zero Hz at low, maximum at high.
// - Overflow gives one constant frequency.
// - Only output one may be control input.
// - Control pulse between 0.5 s and 4 s resets.
// - Fault-range option: linear 3.8 to 20.5, then 22.
// - Fault-range option: 3.6 mA fault, undershoot band.
// - Maximum frequency limited to 50 to 1000 Hz.
// - Overflow frequency 1 to 100 percent of maximum.
`timescale 1ns/1ps
module flow_pulse_frequency_output
  import flow_out_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_MS_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [15:0] vol_inc_i,
  input wire logic vol_valid_i,
  input wire logic [23:0] meas_i,
  input wire logic overflow_i,
  input wire logic fault_i,
  input wire logic measuring_i,
  input wire logic pin1_i,
  output logic pin1_o,
  output logic pin1_oe_o,
  output logic pin2_o,
  output logic pin2_oe_o,
  output logic [14:0] analog_ua_o,
  output logic minmax_reset_o,
  output logic partvol_reset_o
);
  logic [1:0] mode1_r;
  logic [1:0] mode2_r;
  logic ne43_r;
  logic user_unit_r;
  logic ctrl_partvol_r;
  logic [14:0] width_r;
  logic [23:0] pulse_vol_r;
  logic [7:0] user_factor_r;
  logic [10:0] freq_max_r;
  logic [6:0] ovf_pct_r;
  logic [23:0] val_lo_r;
  logic [23:0] val_hi_r;
  logic [15:0] range_end_r;
  logic [31:0] eff_vol_r;
  logic [31:0] nco_inc_r;
  logic realtime_r;
  logic [31:0] div_cnt_r;
  logic tick_r;
  logic [4:0] ref_cnt_r;
  logic refresh_r;
  logic sync1_r;
  logic sync2_r;
  logic lvl_r;
  logic [11:0] high_ms_r;
  logic [15:0] owed1;
  logic [15:0] owed2;
  logic [47:0] span;
  logic [47:0] above;
  logic [47:0] below;
  logic [47:0] ua_up;
  logic [47:0] ua_dn;
  logic [14:0] ua_nxt;
  logic [47:0] inc_nxt;
  logic [63:0] rt_lhs;
  logic [63:0] rt_rhs;
  logic wr_ctrl;

  assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode1_r <= MODE_OFF;
      mode2_r <= MODE_OFF;
      ne43_r <= 1'b0;
      user_unit_r <= 1'b0;
      ctrl_partvol_r <= 1'b0;
    end else if (wr_ctrl) begin
      mode1_r <= wdata_i[1:0];
      mode2_r <= (wdata_i[3:2] == MODE_CTRL) ? MODE_OFF : wdata_i[3:2];
      ne43_r <= wdata_i[4];
      user_unit_r <= wdata_i[5];
      ctrl_partvol_r <= wdata_i[6];
    end
  end

  // Out-of-range settings are clamped on write so the engines never see them.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      width_r <= WIDTH_MS_RST;
      pulse_vol_r <= PULSE_VOL_RST;
      user_factor_r <= USER_FACTOR_RST;
      freq_max_r <= FREQ_MAX_RST;
      ovf_pct_r <= OVF_PCT_RST;
      val_lo_r <= 24'h0;
      val_hi_r <= VAL_HI_RST;
      range_end_r <= RANGE_END_RST;
    end else if (wr_i) begin
      case (addr_i)
        OFS_PULSE_WIDTH: width_r <= (wdata_i[31:15] != 17'h0 || wdata_i[14:0] > WIDTH_MS_MAX)
          ? WIDTH_MS_MAX : (wdata_i[14:0] < WIDTH_MS_MIN) ? WIDTH_MS_MIN
          : wdata_i[14:0];
        OFS_PULSE_VOL: pulse_vol_r <= wdata_i[23:0];
        OFS_USER_FACTOR: user_factor_r <= wdata_i[7:0];
        OFS_FREQ_MAX: freq_max_r <= (wdata_i[31:11] != 21'h0 || wdata_i[10:0] > FREQ_MAX_MAX)
          ? FREQ_MAX_MAX : (wdata_i[10:0] < FREQ_MAX_MIN) ? FREQ_MAX_MIN
          : wdata_i[10:0];
        OFS_OVF_PCT: ovf_pct_r <= (wdata_i[31:7] != 25'h0 || wdata_i[6:0] > OVF_PCT_MAX)
          ? OVF_PCT_MAX : (wdata_i[6:0] < OVF_PCT_MIN) ? OVF_PCT_MIN
          : wdata_i[6:0];
        OFS_VAL_LO: val_lo_r <= wdata_i[23:0];
        OFS_VAL_HI: val_hi_r <= wdata_i[23:0];
        OFS_RANGE_END: range_end_r <= wdata_i[15:0];
        default: range_end_r <= range_end_r;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        OFS_CTRL: rdata_o <= {25'h0, ctrl_partvol_r, user_unit_r, ne43_r, mode2_r, mode1_r};
        OFS_PULSE_WIDTH: rdata_o <= {17'h0, width_r};
        OFS_PULSE_VOL: rdata_o <= {8'h0, pulse_vol_r};
        OFS_USER_FACTOR: rdata_o <= {24'h0, user_factor_r};
        OFS_FREQ_MAX: rdata_o <= {21'h0, freq_max_r};
        OFS_OVF_PCT: rdata_o <= {25'h0, ovf_pct_r};
        OFS_VAL_LO: rdata_o <= {8'h0, val_lo_r};
        OFS_VAL_HI: rdata_o <= {8'h0, val_hi_r};
        OFS_RANGE_END: rdata_o <= {16'h0, range_end_r};
        OFS_STATUS: rdata_o <= {28'h0, measuring_i, overflow_i, lvl_r, realtime_r};
        OFS_OWED1: rdata_o <= {16'h0, owed1};
        OFS_OWED2: rdata_o <= {16'h0, owed2};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_r <= 32'h0;
      tick_r <= 1'b0;
      ref_cnt_r <= 5'h0;
      refresh_r <= 1'b0;
    end else begin
      tick_r <= (div_cnt_r == TICK_CYCLES - 1);
      div_cnt_r <= (div_cnt_r == TICK_CYCLES - 1) ? 32'h0 : div_cnt_r + 32'h1;
      refresh_r <= tick_r && (ref_cnt_r == REFRESH_MS - 5'h1);
      if (tick_r) begin
        ref_cnt_r <= (ref_cnt_r == REFRESH_MS - 5'h1) ? 5'h0 : ref_cnt_r + 5'h1;
      end
    end
  end

  // The user unit factor is litres per unit, so it scales the stored pulse volume.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eff_vol_r <= 32'h0;
      realtime_r <= 1'b0;
    end else begin
      eff_vol_r <= user_unit_r ? {8'h0, pulse_vol_r} * {24'h0, user_factor_r}
        : {8'h0, pulse_vol_r};
      realtime_r <= (rt_lhs <= rt_rhs);
    end
  end

  assign rt_lhs = {48'h0, range_end_r} * {49'h0, width_r} * UL_PER_L;
  assign rt_rhs = RT_LIMIT * {32'h0, eff_vol_r};
  assign span = (val_hi_r > val_lo_r) ? {24'h0, val_hi_r - val_lo_r} : 48'h1;
  assign above = (meas_i > val_lo_r) ? {24'h0, meas_i - val_lo_r} : 48'h0;
  assign below = (meas_i < val_lo_r) ? {24'h0, val_lo_r - meas_i} : 48'h0;
  assign ua_up = {33'h0, UA_4MA} + (above * UA_SPAN) / span;
  assign ua_dn = (below * UA_SPAN) / span;

  always_comb begin
    if (overflow_i) begin
      inc_nxt = ({37'h0, freq_max_r} * {41'h0, ovf_pct_r} * NCO_K) / PCT_FULL;
    end else if (above >= span) begin
      inc_nxt = {37'h0, freq_max_r} * NCO_K;
    end else begin
      inc_nxt = (above * {37'h0, freq_max_r} * NCO_K) / span;
    end
  end

  always_comb begin
    if (!ne43_r) begin
      ua_nxt = (below != 48'h0) ? UA_4MA : (ua_up > {33'h0, UA_20MA}) ? UA_20MA
        : ua_up[14:0];
    end else if (fault_i) begin
      ua_nxt = UA_FAULT;
    end else if (overflow_i || ua_up > {33'h0, UA_HIGH}) begin
      ua_nxt = UA_OVER;
    end else if (below != 48'h0) begin
      ua_nxt = (ua_dn >= {33'h0, UA_4MA - UA_LOW}) ? UA_LOW
        : UA_4MA - ua_dn[14:0];
    end else begin
      ua_nxt = ua_up[14:0];
    end
  end

  // Scaling is re-evaluated each millisecond; the dividers are combinational from meas_i, so they have one clock to settle.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nco_inc_r <= 32'h0;
      analog_ua_o <= UA_4MA;
    end else if (tick_r) begin
      nco_inc_r <= inc_nxt[31:0];
      analog_ua_o <= ua_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      sync1_r <= pin1_i;
      sync2_r <= sync1_r;
      lvl_r <= sync2_r;
    end
  end

  // The high time saturates at the upper bound so a long press is refused, not wrapped.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_ms_r <= 12'h0;
      minmax_reset_o <= 1'b0;
      partvol_reset_o <= 1'b0;
    end else begin
      minmax_reset_o <= 1'b0;
      partvol_reset_o <= 1'b0;
      if (mode1_r != MODE_CTRL || !sync2_r) begin
        high_ms_r <= 12'h0;
      end else if (tick_r && high_ms_r != CTRL_MAX_MS) begin
        high_ms_r <= high_ms_r + 12'h1;
      end
      if (mode1_r == MODE_CTRL && lvl_r && !sync2_r && high_ms_r > CTRL_MIN_MS
          && high_ms_r < CTRL_MAX_MS) begin
        minmax_reset_o <= !ctrl_partvol_r;
        partvol_reset_o <= ctrl_partvol_r;
      end
    end
  end

  pulse_freq_chan u_chan1 (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .mode_i(mode1_r), .tick_ms_i(tick_r),
    .refresh_i(refresh_r), .width_ms_i(width_r), .pulse_vol_i(eff_vol_r),
    .vol_inc_i(vol_inc_i), .vol_valid_i(vol_valid_i), .overflow_i(overflow_i),
    .measuring_i(measuring_i), .nco_inc_i(nco_inc_r), .pin_o(pin1_o),
    .pin_oe_o(pin1_oe_o), .owed_o(owed1)
  );

  pulse_freq_chan u_chan2 (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .mode_i(mode2_r), .tick_ms_i(tick_r),
    .refresh_i(refresh_r), .width_ms_i(width_r), .pulse_vol_i(eff_vol_r),
    .vol_inc_i(vol_inc_i), .vol_valid_i(vol_valid_i), .overflow_i(overflow_i),
    .measuring_i(measuring_i), .nco_inc_i(nco_inc_r), .pin_o(pin2_o),
    .pin_oe_o(pin2_oe_o), .owed_o(owed2)
  );

  a_width_range: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    width_r >= WIDTH_MS_MIN && width_r <= WIDTH_MS_MAX)
    else $error("pulse width outside allowed span");
  a_freq_limits: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (wr_i && addr_i == OFS_FREQ_MAX) |=> freq_max_r >= FREQ_MAX_MIN
      && freq_max_r <= FREQ_MAX_MAX)
    else $error("maximum frequency outside allowed span");
  a_pct_limits: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ovf_pct_r >= OVF_PCT_MIN && ovf_pct_r <= OVF_PCT_MAX)
    else $error("overflow percentage outside allowed span");
  a_out2_no_ctrl: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    mode2_r != MODE_CTRL)
    else $error("second output took control role");
  a_ctrl_window: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (minmax_reset_o || partvol_reset_o) |-> $past(high_ms_r) > CTRL_MIN_MS
      && $past(high_ms_r) < CTRL_MAX_MS && $past(mode1_r) == MODE_CTRL)
    else $error("reset accepted outside pulse window");
  a_fault_level: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (tick_r && ne43_r && fault_i) |=> analog_ua_o == UA_FAULT)
    else $error("fault current not driven");
  a_refresh_tick: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    refresh_r |-> $past(tick_r) && $past(ref_cnt_r) == REFRESH_MS - 5'h1)
    else $error("refresh off the 20 ms boundary");
  c_ctrl_reset: cover property (@(posedge clock_i) disable iff (!arst_n_i) partvol_reset_o);
endmodule

// >>> tb/pulse_counter_model.sv
/*
  Far-side model: a counter input that times and counts pulses on output 1
  and can drive a control pulse onto the same wire. Assumes the testbench
  resolves the wire level from both drivers.
*/
`timescale 1ns/1ps
module pulse_counter_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic ctrl_o,
  output int pulses_o,
  output int high_o
);
  int run;
  logic last;
  initial ctrl_o = 1'b0;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulses_o <= 0;
      high_o <= 0;
      run <= 0;
      last <= 1'b0;
    end else begin
      last <= pin_i;
      run <= pin_i ? run + 1 : 0;
      if (pin_i && !last) begin
        pulses_o <= pulses_o + 1;
      end
      if (!pin_i && last) begin
        high_o <= run;
      end
    end
  end
  // The line is released low between frames, so no stale level lingers.
  task automatic send_ctrl(input int ms, input int tick);
    @(posedge clock_i);
    ctrl_o <= 1'b1;
    repeat (ms * tick) @(posedge clock_i);
    ctrl_o <= 1'b0;
  endtask
endmodule

// >>> tb/flow_pulse_frequency_output_tb_top.sv
/*
  Self-checking testbench for the flow output stage with a shortened
  millisecond tick. Assumes the pulse counter model on output 1.
*/
`timescale 1ns/1ps
module flow_pulse_frequency_output_tb_top;
  import flow_out_pkg::*;
  localparam int TK = 20;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] vol_inc_i = 16'h0;
  logic vol_valid_i = 1'b0;
  logic overflow_i = 1'b0;
  logic fault_i = 1'b0;
  logic measuring_i = 1'b1;
  logic [23:0] meas_i = 24'h0;
  logic [31:0] rdata_o;
  logic pin1_o, pin1_oe_o, pin2_o, pin2_oe_o, minmax_reset_o, partvol_reset_o;
  logic [14:0] analog_ua_o;
  logic ctrl_w, pin_lvl;
  int pulses, high, n_mm = 0, n_pv = 0;
  int run2 = 0, hi2 = 0, lo2 = 0;
  logic last2 = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  always #25 clock_i = ~clock_i;
  assign pin_lvl = pin1_oe_o ? pin1_o : ctrl_w;
  always @(posedge clock_i) begin
    if (minmax_reset_o === 1'b1) n_mm++;
    if (partvol_reset_o === 1'b1) n_pv++;
  end
  // Output 2 run lengths, counted only while the pin is driven.
  always @(posedge clock_i) begin
    last2 <= pin2_o;
    if (pin2_oe_o !== 1'b1) begin
      run2 <= 0;
    end else if (pin2_o !== last2) begin
      if (last2 === 1'b1) begin
        hi2 <= run2;
      end else begin
        lo2 <= run2;
      end
      run2 <= 1;
    end else begin
      run2 <= run2 + 1;
    end
  end
  flow_pulse_frequency_output #(.TICK_CYCLES(TK)) u_flow_pulse_frequency_output (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vol_inc_i(vol_inc_i),
    .vol_valid_i(vol_valid_i), .meas_i(meas_i), .overflow_i(overflow_i),
    .fault_i(fault_i), .measuring_i(measuring_i), .pin1_i(pin_lvl), .pin1_o(pin1_o),
    .pin1_oe_o(pin1_oe_o), .pin2_o(pin2_o), .pin2_oe_o(pin2_oe_o),
    .analog_ua_o(analog_ua_o), .minmax_reset_o(minmax_reset_o),
    .partvol_reset_o(partvol_reset_o));
  pulse_counter_model u_pulse_counter_model (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .pin_i(pin_lvl), .ctrl_o(ctrl_w), .pulses_o(pulses), .high_o(high));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic feed(input int n);
    @(posedge clock_i);
    // Every increment counts, as with the low-flow cutoff set to zero.
    vol_inc_i <= 16'h01f4;
    vol_valid_i <= 1'b1;
    repeat (n) @(posedge clock_i);
    vol_valid_i <= 1'b0;
  endtask
  task automatic t_regs();
    rc(OFS_PULSE_WIDTH, 32'h0000000a);
    rc(OFS_PULSE_VOL, 32'h000186a0);
    rc(OFS_FREQ_MAX, 32'h000001f4);
    rc(8'hfc, 32'h0);
    rc(OFS_STATUS, 32'h00000009);
    wr(OFS_PULSE_WIDTH, 32'h0);
    rc(OFS_PULSE_WIDTH, 32'h00000001);
    wr(OFS_PULSE_WIDTH, 32'h00004e21);
    rc(OFS_PULSE_WIDTH, 32'h00004e20);
    rc(OFS_STATUS, 32'h00000008);
    wr(OFS_FREQ_MAX, 32'h0000000a);
    rc(OFS_FREQ_MAX, 32'h00000032);
    wr(OFS_OVF_PCT, 32'h000000c8);
    rc(OFS_OVF_PCT, 32'h00000064);
  endtask
  task automatic t_pulse();
    int b;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_PULSE_WIDTH, 32'h1);
    wr(OFS_PULSE_VOL, 32'h3e8);
    b = pulses;
    feed(7);
    repeat (1600) @(posedge clock_i);
    chk(pulses - b, 3);
    chk(high, TK);
    chk({31'h0, pin1_oe_o}, 32'h1);
    measuring_i <= 1'b0;
    feed(3);
    repeat (1000) @(posedge clock_i);
    chk(pulses - b, 3);
    rc(OFS_OWED1, 32'h2);
    measuring_i <= 1'b1;
    repeat (1000) @(posedge clock_i);
    chk(pulses - b, 5);
    wr(OFS_USER_FACTOR, 32'h2);
    wr(OFS_CTRL, 32'h21);
    feed(8);
    repeat (1600) @(posedge clock_i);
    chk(pulses - b, 7);
  endtask
  task automatic t_ovf();
    int n;
    n = 0;
    overflow_i <= 1'b1;
    feed(8);
    repeat (60) @(posedge clock_i);
    repeat (800) begin
      @(posedge clock_i);
      if (pin_lvl !== 1'b1) n++;
    end
    chk(n, 0);
    overflow_i <= 1'b0;
  endtask
  task automatic t_ctrl();
    int m, p;
    meas_i <= 24'h00ffff;
    wr(OFS_FREQ_MAX, 32'h000003e8);
    wr(OFS_CTRL, 32'hf);
    rc(OFS_CTRL, 32'h3);
    chk({31'h0, pin1_oe_o}, 32'h0);
    // Output 2 runs at full scale while the control pulses are timed.
    repeat (TK) @(posedge clock_i);
    wr(OFS_CTRL, 32'hb);
    m = n_mm;
    p = n_pv;
    u_pulse_counter_model.send_ctrl(600, TK);
    repeat (100) @(posedge clock_i);
    chk(n_mm - m, 1);
    u_pulse_counter_model.send_ctrl(300, TK);
    repeat (100) @(posedge clock_i);
    chk(n_mm - m, 1);
    wr(OFS_CTRL, 32'h4b);
    u_pulse_counter_model.send_ctrl(600, TK);
    repeat (100) @(posedge clock_i);
    chk(n_pv - p, 1);
    chk({31'h0, hi2 > CLK_HZ / 2000 - 20 && hi2 < CLK_HZ / 2000 + 20}, 32'h1);
    chk({31'h0, (hi2 - lo2) * (hi2 - lo2) <= 4}, 32'h1);
  endtask
  task automatic t_analog();
    wr(OFS_CTRL, 32'h10);
    meas_i <= 24'h008000;
    repeat (3 * TK) @(posedge clock_i);
    chk({17'h0, analog_ua_o}, {17'h0, UA_4MA + ((UA_20MA - UA_4MA) >> 1)});
    fault_i <= 1'b1;
    repeat (3 * TK) @(posedge clock_i);
    chk({17'h0, analog_ua_o}, {17'h0, UA_FAULT});
    fault_i <= 1'b0;
    overflow_i <= 1'b1;
    repeat (3 * TK) @(posedge clock_i);
    chk({17'h0, analog_ua_o}, {17'h0, UA_OVER});
    overflow_i <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_pulse();
    t_ovf();
    t_ctrl();
    t_analog();
    close_out();
  end
  // The run needs about 37000 clocks; a limit of 60000 clocks leaves margin.
  initial begin
    #3_000_000;
    num_errors++;
    close_out();
  end
endmodule
